// *** design/sob_core.sv ***
// Function
// - transmit inserts frame alignment bytes every frame, unscrambled.
// - receiver hunts the byte stream for the alignment pattern.
// - trace/growth slots carry 01,02,03 (STS-3c) or 01 (STS-1), unscrambled.
// - receiver ignores trace and growth slots.
// - section parity over previous scrambled frame, inserted before scrambling.
// - receiver checks section parity, counts each bit error.
// - first pointer pair carries 522 normal flag; others concatenation in STS-3c.
// - receiver reads pointer, flags loss of pointer and path AIS.
// - pointer action bytes sent zero; received only as data on negative stuff.
// - line parity over line overhead and envelope of previous frame, pre-scrambling.
// - receiver checks line parity, counts each bit error.
// - line remote defect sends 110 in maintenance bits 6-8.
// - line AIS forces line overhead and envelope to all ones.
// - receiver decodes maintenance bits 6-8 for line AIS and RDI.
// - line growth byte carries previous interval's line parity errors, 0-24.
// - receiver adds legal line far-end values, discards illegal ones.
// - path parity over previous envelope before scrambling.
// - path parity inserted before scrambling; receiver counts path parity errors.
// - path signal label sent as 13 hex for ATM.
// - path status byte carries path RDI and previous path error count 0-8.
// - receiver adds legal path status counts and detects path RDI.
// - cell offset byte gives distance to next cell boundary; receiver ignores it.
`timescale 1ns/10ps
`default_nettype none
`include "sob_map.svh"
module sob_core
    import sob_pkg::*;
(
    input wire logic i_core_clk, // line byte clock
    input wire logic i_resetn, // async reset, active low
    input wire logic i_sts3c, // 1 STS-3c, 0 STS-1
    input wire logic [7:0] i_tx_data, // cell byte to send
    input wire logic i_tx_line_rdi, // send line RDI
    input wire logic i_tx_line_ais, // send line AIS
    input wire logic i_tx_path_rdi, // send path RDI
    input wire logic [7:0] i_rx_byte, // received line byte
    output logic o_tx_rd, // cell byte taken this cycle
    output logic [7:0] o_tx_byte, // line byte out
    output logic o_tx_frame, // first byte of frame out
    output logic [7:0] o_rx_data, // received cell byte
    output logic o_rx_valid, // rx cell byte strobe
    output logic o_rx_in_frame, // framer locked
    output logic o_rx_lop, // loss of pointer
    output logic o_rx_path_ais, // path AIS seen
    output logic o_rx_line_ais, // line AIS seen
    output logic o_rx_line_rdi, // line RDI seen
    output logic o_rx_path_rdi, // path RDI seen
    output logic [`SOB_CNT_W-1:0] o_cnt_b1, // section parity errors
    output logic [`SOB_CNT_W-1:0] o_cnt_b2, // line parity errors
    output logic [`SOB_CNT_W-1:0] o_cnt_b3, // path parity errors
    output logic [`SOB_CNT_W-1:0] o_cnt_lfebe, // line far-end errors
    output logic [`SOB_CNT_W-1:0] o_cnt_pfebe // path far-end errors
);

    // ****************************************
    // helper functions
    // ****************************************

    // scrambler step, msb first: returns {next state, key byte}
    function automatic logic [14:0] sob_scr(input logic [6:0] st);
        logic [6:0] s;
        logic [7:0] k;
        s = st;
        k = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            k[i] = s[6];
            s = {s[5:0], s[6] ^ s[5]};
        end
        return {s, k};
    endfunction

    // next frame position: {col, row, sub}
    function automatic logic [15:0] sob_adv(input logic [9:0] col, input logic [3:0] row,
                                            input logic [1:0] sub, input logic sts3c);
        logic [9:0] ncol;
        logic [1:0] nmax;
        logic [9:0] c;
        logic [3:0] r;
        logic [1:0] b;
        ncol = sts3c ? `SOB_COLS_3 : `SOB_COLS_1;
        nmax = sts3c ? 2'h2 : 2'h0;
        c = col + 10'h001;
        r = row;
        b = (sub == nmax) ? 2'h0 : sub + 2'h1;
        if (col == ncol - 10'h001) begin
            c = 10'h000;
            b = 2'h0;
            r = (row == `SOB_ROWS - 4'h1) ? 4'h0 : row + 4'h1;
        end
        return {c, r, b};
    endfunction

    // overhead slot of a column: 0,1,2 or 3 outside overhead
    function automatic logic [1:0] sob_slot(input logic [9:0] col, input logic sts3c);
        logic [1:0] sl;
        sl = 2'h3;
        if (sts3c) begin
            if (col < 10'h003) begin
                sl = 2'h0;
            end else if (col < 10'h006) begin
                sl = 2'h1;
            end else if (col < 10'h009) begin
                sl = 2'h2;
            end
        end else if (col < 10'h003) begin
            sl = col[1:0];
        end
        return sl;
    endfunction

    // line growth slot test
    function automatic logic sob_is_m1(input logic [1:0] sl, input logic [1:0] sub, input logic sts3c);
        return sts3c ? (sl == 2'h2 && sub == 2'h2) : (sl == 2'h1);
    endfunction

    function automatic logic [3:0] sob_pop(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction

    // ****************************************
    // state
    // ****************************************

    sob_state_t s;
    sob_state_t next_s;

    logic [9:0] toh_w;
    logic [9:0] last_col;
    logic [15:0] tx_pos;
    logic [15:0] rx_pos;
    logic [1:0] tx_sl;
    logic [1:0] rx_sl;
    logic [14:0] tx_k;
    logic [14:0] rx_k;
    logic [7:0] raw;
    logic [7:0] out;
    logic [7:0] desc;
    logic [9:0] ptr;
    logic tx_row0oh;
    logic rx_row0oh;
    logic tx_last;
    logic rx_last;

    // ****************************************
    // transmit and receive processing
    // ****************************************
    always_comb begin
        next_s = s;
        toh_w = i_sts3c ? `SOB_TOH_3 : `SOB_TOH_1;
        last_col = (i_sts3c ? `SOB_COLS_3 : `SOB_COLS_1) - 10'h001;
        tx_pos = sob_adv(s.tx_col, s.tx_row, s.tx_sub, i_sts3c);
        rx_pos = sob_adv(s.rx_col, s.rx_row, s.rx_sub, i_sts3c);
        tx_sl = sob_slot(s.tx_col, i_sts3c);
        rx_sl = sob_slot(s.rx_col, i_sts3c);
        tx_row0oh = (s.tx_row == 4'h0) && (tx_sl != 2'h3);
        rx_row0oh = (s.rx_row == 4'h0) && (rx_sl != 2'h3);
        tx_last = (s.tx_row == `SOB_ROWS - 4'h1) && (s.tx_col == last_col);
        rx_last = (s.rx_row == `SOB_ROWS - 4'h1) && (s.rx_col == last_col);
        // restart at first byte after row-0 overhead
        tx_k = sob_scr((s.tx_row == 4'h0 && s.tx_col == toh_w) ? `SOB_SCR_SEED : s.tx_scr);
        rx_k = sob_scr((s.rx_row == 4'h0 && s.rx_col == toh_w) ? `SOB_SCR_SEED : s.rx_scr);
        raw = 8'h00;
        ptr = {s.rx_h1[1:0], 8'h00};

        // transmit byte before scrambling
        if (tx_sl != 2'h3) begin
            case (s.tx_row)
                4'h0: begin
                    if (tx_sl == 2'h0) begin
                        raw = `SOB_A1;
                    end else if (tx_sl == 2'h1) begin
                        raw = `SOB_A2;
                    end else begin
                        raw = {6'h00, s.tx_sub} + 8'h01;
                    end
                end
                4'h1: begin
                    raw = (tx_sl == 2'h0 && s.tx_sub == 2'h0) ? s.tx_b1 : 8'h00;
                end
                4'h3: begin
                    if (tx_sl == 2'h0) begin
                        raw = (s.tx_sub == 2'h0) ? `SOB_H1_PTR : `SOB_H1_CONC;
                    end else if (tx_sl == 2'h1) begin
                        raw = (s.tx_sub == 2'h0) ? `SOB_H2_PTR : `SOB_H2_CONC;
                    end
                end
                4'h4: begin
                    if (tx_sl == 2'h0) begin
                        raw = s.tx_b2[s.tx_sub];
                    end else if (tx_sl == 2'h2 && s.tx_sub == 2'h0) begin
                        raw = {5'h00, i_tx_line_rdi ? `SOB_K2_RDI : 3'h0};
                    end
                end
                4'h8: begin
                    raw = sob_is_m1(tx_sl, s.tx_sub, i_sts3c) ? {3'h0, s.b2_last} : 8'h00;
                end
                default: begin
                    raw = 8'h00;
                end
            endcase
        end else if (s.tx_col == toh_w) begin
            case (s.tx_row)
                4'h1: raw = s.tx_b3;
                4'h2: raw = `SOB_C2_ATM;
                4'h3: raw = {s.b3_last, i_tx_path_rdi, 3'h0};
                4'h5: raw = (s.tx_cell == 6'h00) ? 8'h00 : {2'h0, `SOB_CELL_LEN - s.tx_cell};
                default: raw = 8'h00;
            endcase
        end else begin
            raw = i_tx_data;
        end
        // line AIS overwrites line overhead and envelope
        if (i_tx_line_ais && (s.tx_row > 4'h2 || tx_sl == 2'h3)) begin
            raw = 8'hFF;
        end

        out = tx_row0oh ? raw : raw ^ tx_k[7:0];
        next_s.tx_scr = tx_k[14:8];
        next_s.tx_byte = out;
        next_s.tx_frame = (s.tx_row == 4'h0) && (s.tx_col == 10'h000);
        next_s.tx_col = tx_pos[15:6];
        next_s.tx_row = tx_pos[5:2];
        next_s.tx_sub = tx_pos[1:0];
        next_s.tx_rd = (sob_slot(tx_pos[15:6], i_sts3c) == 2'h3) && (tx_pos[15:6] != toh_w);
        if (s.tx_rd) begin
            next_s.tx_cell = (s.tx_cell == `SOB_CELL_LEN - 6'h01) ? 6'h00 : s.tx_cell + 6'h01;
        end

        next_s.tx_b1_acc = s.tx_b1_acc ^ out;
        // line parity, one per interleaved column
        if (s.tx_row > 4'h2 || tx_sl == 2'h3) begin
            next_s.tx_b2_acc[s.tx_sub] = s.tx_b2_acc[s.tx_sub] ^ raw;
        end
        if (tx_sl == 2'h3) begin
            next_s.tx_b3_acc = s.tx_b3_acc ^ raw;
        end
        if (tx_last) begin
            next_s.tx_b1 = next_s.tx_b1_acc;
            next_s.tx_b2 = next_s.tx_b2_acc;
            next_s.tx_b3 = next_s.tx_b3_acc;
            next_s.tx_b1_acc = 8'h00;
            next_s.tx_b2_acc = '0;
            next_s.tx_b3_acc = 8'h00;
        end

        // receive framer
        next_s.rx_prev = i_rx_byte;
        next_s.rx_valid = 1'b0;
        next_s.rx_col = rx_pos[15:6];
        next_s.rx_row = rx_pos[5:2];
        next_s.rx_sub = rx_pos[1:0];
        next_s.rx_scr = rx_k[14:8];
        desc = rx_row0oh ? i_rx_byte : i_rx_byte ^ rx_k[7:0];
        case (s.rx_fsm)
            SOB_HUNT: begin
                // hunt for last A1 then first A2
                if (s.rx_prev == `SOB_A1 && i_rx_byte == `SOB_A2) begin
                    next_s.rx_fsm = SOB_SYNC;
                    next_s.rx_in_frame = 1'b1;
                    next_s.rx_col = (i_sts3c ? 10'h003 : 10'h001) + 10'h001;
                    next_s.rx_row = 4'h0;
                    next_s.rx_sub = i_sts3c ? 2'h1 : 2'h0;
                    // alignment bytes up to the first A2 already passed; no reference parity yet
                    next_s.rx_ref = 1'b0;
                    next_s.rx_b1_acc = `SOB_A1 ^ `SOB_A2;
                    next_s.rx_b2_acc = '0;
                    next_s.rx_b3_acc = 8'h00;
                    next_s.b2_int = 5'h00;
                    next_s.b3_int = 4'h0;
                end
            end
            SOB_SYNC: begin
                if (s.rx_row == 4'h0 && s.rx_col == (i_sts3c ? 10'h003 : 10'h001) &&
                    !(s.rx_prev == `SOB_A1 && i_rx_byte == `SOB_A2)) begin
                    next_s.rx_fsm = SOB_HUNT;
                    next_s.rx_in_frame = 1'b0;
                end
            end
            default: begin
                next_s.rx_fsm = SOB_HUNT;
                next_s.rx_in_frame = 1'b0;
            end
        endcase

        if (s.rx_fsm == SOB_SYNC) begin
            // trace and growth fall through untouched
            next_s.rx_b1_acc = s.rx_b1_acc ^ i_rx_byte;
            if (s.rx_row > 4'h2 || rx_sl == 2'h3) begin
                next_s.rx_b2_acc[s.rx_sub] = s.rx_b2_acc[s.rx_sub] ^ desc;
            end
            if (rx_sl == 2'h3) begin
                next_s.rx_b3_acc = s.rx_b3_acc ^ desc;
            end
            if (rx_sl != 2'h3) begin
                case (s.rx_row)
                    4'h1: begin
                        if (rx_sl == 2'h0 && s.rx_sub == 2'h0 && s.rx_ref) begin
                            next_s.cnt_b1 = s.cnt_b1 + `SOB_CNT_W'(sob_pop(desc ^ s.rx_b1));
                        end
                    end
                    4'h3: begin
                        if (rx_sl == 2'h0 && s.rx_sub == 2'h0) begin
                            next_s.rx_h1 = desc;
                        end else if (rx_sl == 2'h1 && s.rx_sub == 2'h0) begin
                            ptr = {s.rx_h1[1:0], desc};
                            next_s.rx_pais = (s.rx_h1 == 8'hFF) && (desc == 8'hFF);
                            if (s.rx_h1 == 8'hFF && desc == 8'hFF) begin
                                next_s.rx_lop = 1'b0;
                            end else if ((s.rx_h1[7:4] == `SOB_NDF_NORM || s.rx_h1[7:4] == `SOB_NDF_SET) &&
                                         ptr <= `SOB_PTR_MAX) begin
                                next_s.rx_lop = 1'b0;
                                next_s.rx_ptr = ptr;
                            end else if (((ptr ^ s.rx_ptr) & `SOB_PTR_DBITS) == `SOB_PTR_DBITS) begin
                                next_s.rx_neg = 1'b1;
                            end else begin
                                next_s.rx_lop = 1'b1;
                            end
                        end else if (rx_sl == 2'h2 && s.rx_neg) begin
                            // action bytes carry data on negative stuff
                            next_s.rx_data = desc;
                            next_s.rx_valid = 1'b1;
                            next_s.rx_neg = (s.rx_sub != (i_sts3c ? 2'h2 : 2'h0));
                        end
                    end
                    4'h4: begin
                        if (rx_sl == 2'h0 && s.rx_ref) begin
                            next_s.cnt_b2 = s.cnt_b2 + `SOB_CNT_W'(sob_pop(desc ^ s.rx_b2[s.rx_sub]));
                            next_s.b2_int = s.b2_int + {1'b0, sob_pop(desc ^ s.rx_b2[s.rx_sub])};
                        end else if (rx_sl == 2'h2 && s.rx_sub == 2'h0) begin
                            next_s.rx_lais = (desc[2:0] == `SOB_K2_AIS);
                            next_s.rx_lrdi = (desc[2:0] == `SOB_K2_RDI);
                        end
                    end
                    4'h8: begin
                        if (sob_is_m1(rx_sl, s.rx_sub, i_sts3c) && desc <= `SOB_M1_MAX) begin
                            next_s.cnt_lfebe = s.cnt_lfebe + `SOB_CNT_W'(desc);
                        end
                    end
                    default: begin
                        next_s.rx_valid = 1'b0;
                    end
                endcase
            end else if (s.rx_col == toh_w) begin
                if (s.rx_row == 4'h1 && s.rx_ref) begin
                    next_s.cnt_b3 = s.cnt_b3 + `SOB_CNT_W'(sob_pop(desc ^ s.rx_b3));
                    next_s.b3_int = sob_pop(desc ^ s.rx_b3);
                end else if (s.rx_row == 4'h3) begin
                    next_s.rx_prdi = desc[3];
                    if (desc[7:4] <= `SOB_G1_MAX) begin
                        next_s.cnt_pfebe = s.cnt_pfebe + `SOB_CNT_W'(desc[7:4]);
                    end
                end
            end else begin
                // cell offset ignored; payload passed on
                next_s.rx_data = desc;
                next_s.rx_valid = 1'b1;
            end
            if (rx_last) begin
                next_s.rx_b1 = next_s.rx_b1_acc;
                next_s.rx_b2 = next_s.rx_b2_acc;
                next_s.rx_b3 = next_s.rx_b3_acc;
                next_s.rx_b1_acc = 8'h00;
                next_s.rx_b2_acc = '0;
                next_s.rx_b3_acc = 8'h00;
                next_s.b2_last = s.b2_int;
                next_s.b3_last = s.b3_int;
                next_s.b2_int = 5'h00;
                next_s.rx_ref = 1'b1;
            end
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from state
    assign o_tx_rd = s.tx_rd;
    assign o_tx_byte = s.tx_byte;
    assign o_tx_frame = s.tx_frame;
    assign o_rx_data = s.rx_data;
    assign o_rx_valid = s.rx_valid;
    assign o_rx_in_frame = s.rx_in_frame;
    assign o_rx_lop = s.rx_lop;
    assign o_rx_path_ais = s.rx_pais;
    assign o_rx_line_ais = s.rx_lais;
    assign o_rx_line_rdi = s.rx_lrdi;
    assign o_rx_path_rdi = s.rx_prdi;
    assign o_cnt_b1 = s.cnt_b1;
    assign o_cnt_b2 = s.cnt_b2;
    assign o_cnt_b3 = s.cnt_b3;
    assign o_cnt_lfebe = s.cnt_lfebe;
    assign o_cnt_pfebe = s.cnt_pfebe;

endmodule
`default_nettype wire

// *** pkg/sob_map.svh ***
`ifndef SOB_MAP_SVH
`define SOB_MAP_SVH
// frame geometry
`define SOB_ROWS 4'h9
`define SOB_COLS_1 10'h05A
`define SOB_COLS_3 10'h10E
`define SOB_TOH_1 10'h003
`define SOB_TOH_3 10'h009
`define SOB_CELL_LEN 6'h35
// fixed transmit overhead values and received line AIS code
`define SOB_A1 8'hF6
`define SOB_A2 8'h28
`define SOB_H1_PTR 8'h62
`define SOB_H2_PTR 8'h0A
`define SOB_H1_CONC 8'h93
`define SOB_H2_CONC 8'hFF
`define SOB_C2_ATM 8'h13
`define SOB_K2_RDI 3'h6
`define SOB_K2_AIS 3'h7
// legal far-end counts and pointer limits
`define SOB_M1_MAX 8'h18
`define SOB_G1_MAX 4'h8
`define SOB_PTR_MAX 10'h30E
`define SOB_PTR_DBITS 10'h155
`define SOB_NDF_NORM 4'h6
`define SOB_NDF_SET 4'h9
// scrambler seed, counter width
`define SOB_SCR_SEED 7'h7F
`define SOB_CNT_W 16
`endif

// *** pkg/sob_pkg.sv ***
`include "sob_map.svh"
package sob_pkg;
    typedef enum logic [0:0] {
        SOB_HUNT = 1'b0,
        SOB_SYNC = 1'b1
    } sob_fsm_t;

    typedef struct packed {
        // transmit side
        logic [9:0] tx_col;
        logic [3:0] tx_row;
        logic [1:0] tx_sub;
        logic [6:0] tx_scr;
        logic [7:0] tx_b1;
        logic [7:0] tx_b1_acc;
        logic [2:0][7:0] tx_b2;
        logic [2:0][7:0] tx_b2_acc;
        logic [7:0] tx_b3;
        logic [7:0] tx_b3_acc;
        logic [5:0] tx_cell;
        logic tx_rd;
        logic [7:0] tx_byte;
        logic tx_frame;
        // receive side
        sob_fsm_t rx_fsm;
        logic rx_in_frame;
        logic rx_ref;
        logic [7:0] rx_prev;
        logic [9:0] rx_col;
        logic [3:0] rx_row;
        logic [1:0] rx_sub;
        logic [6:0] rx_scr;
        logic [7:0] rx_b1;
        logic [7:0] rx_b1_acc;
        logic [2:0][7:0] rx_b2;
        logic [2:0][7:0] rx_b2_acc;
        logic [7:0] rx_b3;
        logic [7:0] rx_b3_acc;
        logic [7:0] rx_h1;
        logic [9:0] rx_ptr;
        logic rx_neg;
        logic rx_lop;
        logic rx_pais;
        logic rx_lais;
        logic rx_lrdi;
        logic rx_prdi;
        logic [4:0] b2_int;
        logic [4:0] b2_last;
        logic [3:0] b3_int;
        logic [3:0] b3_last;
        logic [`SOB_CNT_W-1:0] cnt_b1;
        logic [`SOB_CNT_W-1:0] cnt_b2;
        logic [`SOB_CNT_W-1:0] cnt_b3;
        logic [`SOB_CNT_W-1:0] cnt_lfebe;
        logic [`SOB_CNT_W-1:0] cnt_pfebe;
        logic [7:0] rx_data;
        logic rx_valid;
    } sob_state_t;
endpackage

// *** verification/sob_core_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "sob_map.svh"
module sob_core_sva (
    input wire logic i_core_clk, // clock
    input wire logic i_resetn, // reset
    input wire logic i_sts3c, // mode
    input wire logic [7:0] i_rx_byte, // line in
    input wire logic o_tx_rd, // take
    input wire logic [7:0] o_tx_byte, // line out
    input wire logic o_tx_frame, // frame mark
    input wire logic o_rx_valid, // rx strobe
    input wire logic o_rx_in_frame, // locked
    input wire logic [`SOB_CNT_W-1:0] o_cnt_b1, // b1 count
    input wire logic [`SOB_CNT_W-1:0] o_cnt_b2, // b2 count
    input wire logic [`SOB_CNT_W-1:0] o_cnt_b3 // b3 count
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    logic [11:0] gap;
    logic seen;
    // cycles since last frame mark
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            gap <= 12'h000;
            seen <= 1'b0;
        end else begin
            gap <= o_tx_frame ? 12'h001 : gap + 12'h001;
            seen <= seen | o_tx_frame;
        end
    end
    sequence s_hdr1;
        (o_tx_byte == `SOB_A1) ##1 (o_tx_byte == `SOB_A2) ##1 (o_tx_byte == 8'h01);
    endsequence
    sequence s_hdr3;
        (o_tx_byte == `SOB_A1)[*3] ##1 (o_tx_byte == `SOB_A2)[*3] ##1 (o_tx_byte == 8'h01) ##1
            (o_tx_byte == 8'h02) ##1 (o_tx_byte == 8'h03);
    endsequence
    property p_hdr1;
        o_tx_frame && !i_sts3c |-> s_hdr1;
    endproperty
    a_hdr1: assert property (p_hdr1) else $error("bad sts1 header");
    property p_hdr3;
        o_tx_frame && i_sts3c |-> s_hdr3;
    endproperty
    a_hdr3: assert property (p_hdr3) else $error("bad sts3c header");
    property p_gap;
        o_tx_frame && seen |-> gap == (i_sts3c ? 12'h97E : 12'h32A);
    endproperty
    a_gap: assert property (p_gap) else $error("bad frame spacing");
    property p_rdq;
        o_tx_frame |-> (!o_tx_rd)[*3];
    endproperty
    a_rdq: assert property (p_rdq) else $error("data taken in overhead");
    property p_lock;
        $rose(o_rx_in_frame) |-> $past(i_rx_byte) == `SOB_A2 && $past(i_rx_byte, 2) == `SOB_A1;
    endproperty
    a_lock: assert property (p_lock) else $error("lock without alignment");
    property p_valid;
        o_rx_valid |-> o_rx_in_frame;
    endproperty
    a_valid: assert property (p_valid) else $error("data out while hunting");
    property p_hunt;
        !o_rx_in_frame && !$past(o_rx_in_frame) |-> $stable({o_cnt_b1, o_cnt_b2, o_cnt_b3});
    endproperty
    a_hunt: assert property (p_hunt) else $error("count while hunting");
    property p_bip;
        (o_cnt_b1 - $past(o_cnt_b1)) <= 16'h0008 && (o_cnt_b3 - $past(o_cnt_b3)) <= 16'h0008 &&
            (o_cnt_b2 - $past(o_cnt_b2)) <= (i_sts3c ? 16'h0018 : 16'h0008);
    endproperty
    a_bip: assert property (p_bip) else $error("parity step too big");
endmodule
`default_nettype wire

// *** verification/sob_far_end.sv ***
`timescale 1ns/10ps
`default_nettype none
module sob_far_end (
    input wire logic i_core_clk, // byte clock
    input wire logic i_en, // echo, else filler
    input wire logic i_frame, // frame start in
    input wire logic [7:0] i_line, // from device
    input wire logic [11:0] i_pos, // first bad byte
    input wire logic [11:0] i_len, // bad byte count
    input wire logic [7:0] i_mask, // bits flipped
    output logic [7:0] o_line = 8'h00 // to device
);
    logic [11:0] p = 12'h000;
    logic [11:0] q;
    logic [7:0] fill = 8'h00;
    assign q = i_frame ? 12'h000 : p;
    // echo with corruption; counting filler never aligns
    always @(posedge i_core_clk) begin
        p <= q + 12'h001;
        fill <= fill + 8'h01;
        o_line <= !i_en ? fill : (q >= i_pos && q - i_pos < i_len) ? i_line ^ i_mask : i_line;
    end
endmodule
`default_nettype wire

// *** verification/test_sonet_overhead_byte_processor.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module test_sonet_overhead_byte_processor;
    logic i_core_clk = 1'b0, i_resetn = 1'b0, i_sts3c = 1'b0, i_tx_line_rdi = 1'b0, i_tx_line_ais = 1'b0;
    logic i_tx_path_rdi = 1'b0, o_tx_rd, o_tx_frame, o_rx_valid, o_rx_in_frame, o_rx_lop, o_rx_path_ais;
    logic o_rx_line_ais, o_rx_line_rdi, o_rx_path_rdi, loop = 1'b0, sync = 1'b1, chk = 1'b1;
    logic [7:0] i_tx_data = 8'h00, i_rx_byte, o_tx_byte, o_rx_data, mask = 8'h00;
    logic [7:0] txb [4096];
    logic [11:0] pos = 12'h000, len = 12'h000, tn = 12'h000, rn = 12'h000, mark = 12'h000;
    logic [15:0] o_cnt_b1, o_cnt_b2, o_cnt_b3, o_cnt_lfebe, o_cnt_pfebe;
    logic [31:0] seed = 32'h0000_38a9;
    int num_errors = 0, total_checks = 0, cyc = 0, nv = 0, n;
    sob_core dut (.i_core_clk, .i_resetn, .i_sts3c, .i_tx_data, .i_tx_line_rdi, .i_tx_line_ais, .i_tx_path_rdi,
        .i_rx_byte, .o_tx_rd, .o_tx_byte, .o_tx_frame, .o_rx_data, .o_rx_valid, .o_rx_in_frame, .o_rx_lop,
        .o_rx_path_ais, .o_rx_line_ais, .o_rx_line_rdi, .o_rx_path_rdi, .o_cnt_b1, .o_cnt_b2, .o_cnt_b3,
        .o_cnt_lfebe, .o_cnt_pfebe);
    sob_far_end far (.i_core_clk, .i_en(loop), .i_frame(o_tx_frame), .i_line(o_tx_byte), .i_pos(pos),
        .i_len(len), .i_mask(mask), .o_line(i_rx_byte));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic int fl(input logic s); // frame length
        return s ? 2430 : 810;
    endfunction
    function automatic int pl(input logic s); // payload bytes per frame
        return 9 * (fl(s) / 9 - (s ? 10 : 4));
    endfunction
    function automatic logic [11:0] ps(input logic s, input int r, input int c); // byte position
        return 12'(r * fl(s) / 9 + c);
    endfunction
    task automatic wf(input int k);
        repeat (k * fl(i_sts3c)) @(negedge i_core_clk);
    endtask
    task automatic complete_run();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial forever #4 i_core_clk = ~i_core_clk;
    // random cell bytes at falling edge
    always @(negedge i_core_clk) begin
        seed = xs(seed);
        i_tx_data <= seed[7:0];
    end
    // record sent payload, compare received payload, timeout
    always @(posedge i_core_clk) begin
        cyc++;
        if (o_tx_frame) mark = tn;
        if (o_tx_rd) begin
            txb[tn] = i_tx_data;
            tn++;
        end
        if (!o_rx_in_frame) sync = 1'b1;
        else if (o_rx_valid) begin
            if (sync) rn = mark;
            sync = 1'b0;
            if (chk) `CHK(o_rx_data, txb[rn])
            rn++;
            nv++;
        end
        if (cyc == 90000) begin
            num_errors++;
            complete_run();
        end
    end
    // both modes, reset between them
    initial begin
        for (int m = 0; m < 2; m++) begin
            {i_resetn, i_sts3c, loop, chk, i_tx_line_ais, len} = {1'b0, m[0], 2'h1, 1'b0, 12'h000};
            n = m ? 3 : 1;
            repeat (16) @(negedge i_core_clk);
            i_resetn = 1'b1;
            wf(2);
            `CHK({o_rx_in_frame, o_cnt_b1}, 17'h0)
            loop = 1'b1;
            wf(3);
            `CHK({o_rx_in_frame, o_rx_lop, o_rx_path_ais, o_rx_line_ais, o_rx_line_rdi, o_rx_path_rdi}, 6'h20)
            `CHK({o_cnt_b1, o_cnt_b2, o_cnt_b3, o_cnt_lfebe, o_cnt_pfebe}, 80'h0)
            nv = 0;
            wf(1);
            `CHK(nv, pl(i_sts3c))
            // one bit flipped in row 4 of the path column
            {pos, len, mask} = {ps(i_sts3c, 4, 3 * n), 12'h001, 8'h01};
            wf(2);
            len = 12'h000;
            wf(3);
            `CHK({o_cnt_b1, o_cnt_b2, o_cnt_b3}, {3{16'h0002}})
            `CHK({o_cnt_lfebe, o_cnt_pfebe}, {2{16'h0002}})
            {i_tx_line_rdi, i_tx_path_rdi} = 2'h3;
            wf(2);
            `CHK({o_rx_line_rdi, o_rx_path_rdi, o_rx_line_ais}, 3'h6)
            {i_tx_line_rdi, i_tx_path_rdi, i_tx_line_ais, chk} = 4'h2;
            wf(2);
            `CHK({o_rx_in_frame, o_rx_line_ais, o_rx_path_ais}, 3'h7)
            i_tx_line_ais = 1'b0;
            // pointer pushed out of range, not all ones
            {pos, len, mask} = {ps(i_sts3c, 3, 0), 12'(2 * n), 8'h05};
            wf(2);
            `CHK({o_rx_lop, o_rx_path_ais, o_rx_line_ais}, 3'h4)
            len = 12'h000;
            wf(2);
            `CHK({o_rx_lop, o_rx_in_frame}, 2'h1)
        end
        complete_run();
    end
endmodule
bind sob_core sob_core_sva sva (.i_core_clk, .i_resetn, .i_sts3c, .i_rx_byte, .o_tx_rd, .o_tx_byte, .o_tx_frame,
    .o_rx_valid, .o_rx_in_frame, .o_cnt_b1, .o_cnt_b2, .o_cnt_b3);
`default_nettype wire
